// ### hdl/uss_cfg.svh
/*
 Constants of the synchronous shift serial block: machine cycle phases,
 shifter patterns and data width. Assumes inclusion by bare name.
*/
`ifndef USS_CFG_SVH
`define USS_CFG_SVH
`define USS_DW 8
`define USS_FIFO_DEPTH 4
`define USS_PH_W 2
`define USS_PH_FIRST 2'h0
`define USS_PH_RISE 2'h2
`define USS_PH_LAST 2'h3
`define USS_TX_MARK 1'h1
`define USS_TX_LAST 8'h01
`define USS_RX_PRELOAD 8'hfe
`define USS_PINS_IDLE 3'h4
`endif

// ### hdl/uss_pkg.sv
/*
 Types of the synchronous shift serial block.
 Assumes uss_cfg.svh on the include path.
*/
`include "uss_cfg.svh"
package uss_pkg;
  // Link engine states, one-hot
  typedef enum logic [2:0] {
    USS_IDLE = 3'h1,
    USS_TX = 3'h2,
    USS_RX = 3'h4
  } uss_state_t;
  // Link pin drive bundle
  typedef struct packed {
    logic sck;
    logic dout;
    logic doe;
  } uss_pins_t;
  // Completion flags seen by software
  typedef struct packed {
    logic tx_done;
    logic rx_done;
  } uss_flags_t;
endpackage

// ### hdl/uss_shift_top.sv
/*
 Synchronous shift mode serial port: software side on clk_i, shift engine
 on link_clk_i, and a small transmit FIFO between software and engine.
 Assumes the peer clocks on the shift clock and that the pin wire is
 resolved outside from data_oe_o.
*/
`timescale 1ns/1ns
`include "uss_cfg.svh"

// Transmit word FIFO; depth must be a power of two so pointers wrap freely
module uss_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp, next_wp, rp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic push, pop;

  // Honest full and empty from the word count
  always_comb begin
    in_ready_o = cnt < (AW+1)'(D); // room while fewer than D words are held
    out_valid_o = (cnt != '0);
    out_data_o = mem[rp];
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    next_wp = push ? wp + 1'b1 : wp;
    next_rp = pop ? rp + 1'b1 : rp;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  // Storage holds no reset; only written words are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp] <= in_data_i;
    end
  end
endmodule

// Contract
// - Buffer write starts a transmission
// - Load byte with marker one in ninth bit
// - Shifting begins on next machine cycle
// - Send active drives shifter bit on data
// - Send active enables shift clock output
// - Shift right each clock, LSB first
// - Zero enters transmit shifter from left
// - Last shift, end send, set transmit done
// - Receive starts when enabled and done clear
// - Preload receive shifter with 11111110
// - Receive active next phase enables clock
// - Shift left, sampled data enters right
// - Zero at left: last shift, fill buffer
// - Then end receive, set receive done
module uss_shift_top
  import uss_pkg::*;
(
  // Core clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Link clock
  input wire logic link_clk_i,
  // Software side
  input wire logic wr_i,
  input wire logic [`USS_DW-1:0] wr_data_i,
  output logic wr_ready_o,
  input wire logic receive_enable_i,
  input wire logic tx_clear_i,
  input wire logic rx_clear_i,
  output logic [`USS_DW-1:0] serial_buffer_o,
  output logic transmit_done_flag_o,
  output logic receive_done_flag_o,
  // Link pins
  output logic shift_clk_o,
  input wire logic data_i,
  output logic data_o,
  output logic data_oe_o
);
  // Core domain state
  logic ff_valid, ff_ready;
  logic [`USS_DW-1:0] ff_data;
  logic [`USS_DW-1:0] tx_word, next_tx_word, serial_buffer, next_serial_buffer;
  logic req_tgl, next_req_tgl, rx_go, next_rx_go;
  uss_flags_t flags, next_flags;
  logic ack1, ack2, ack3, rxt1, rxt2, rxt3;
  logic tx_busy, ack_ev, rx_ev;
  // Link domain state
  uss_state_t state, next_state;
  logic [`USS_PH_W-1:0] phase, next_phase;
  logic [`USS_DW:0] tx_sh, next_tx_sh;
  logic [`USS_DW-1:0] rx_sh, next_rx_sh, rx_byte, next_rx_byte;
  logic tx_pend, next_tx_pend, rx_hold, next_rx_hold;
  logic done_tgl, next_done_tgl, rx_tgl, next_rx_tgl;
  uss_pins_t pins, next_pins;
  logic rst1, rst_l, req1, req2, req3, go1, go_s, din1, din_s;
  logic shift_ev, tx_last, rx_last;

  uss_fifo #(.W(`USS_DW), .D(`USS_FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(wr_i),
    .in_ready_o(wr_ready_o),
    .in_data_i(wr_data_i),
    .out_valid_o(ff_valid),
    .out_ready_i(ff_ready),
    .out_data_o(ff_data)
  );

  // Core side: hand words to the engine, catch completions
  always_comb begin
    tx_busy = req_tgl != ack2;
    ack_ev = ack2 != ack3;
    rx_ev = rxt2 != rxt3;
    ff_ready = !tx_busy; // engine back-pressure reaches the FIFO
    next_req_tgl = req_tgl;
    next_tx_word = tx_word;
    next_serial_buffer = serial_buffer;
    next_flags = flags;
    if (ff_valid && ff_ready) begin
      next_tx_word = ff_data;
      next_req_tgl = !req_tgl;
    end
    // Set wins over a clear in the same cycle
    if (tx_clear_i) next_flags.tx_done = 1'b0;
    if (ack_ev) next_flags.tx_done = 1'b1;
    if (rx_clear_i) next_flags.rx_done = 1'b0;
    if (rx_ev) begin
      next_serial_buffer = rx_byte; // stable until the next reception
      next_flags.rx_done = 1'b1;
    end
    next_rx_go = receive_enable_i && !next_flags.rx_done;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      req_tgl <= 1'b0;
      tx_word <= '0;
      serial_buffer <= '0;
      flags <= '0;
      rx_go <= 1'b0;
      {ack1, ack2, ack3, rxt1, rxt2, rxt3} <= '0;
    end else begin
      req_tgl <= next_req_tgl;
      tx_word <= next_tx_word;
      serial_buffer <= next_serial_buffer;
      flags <= next_flags;
      rx_go <= next_rx_go;
      {ack1, ack2, ack3} <= {done_tgl, ack1, ack2};
      {rxt1, rxt2, rxt3} <= {rx_tgl, rxt1, rxt2};
    end
  end

  assign serial_buffer_o = serial_buffer;
  assign transmit_done_flag_o = flags.tx_done;
  assign receive_done_flag_o = flags.rx_done;

  // Link side synchronisers; first stages feed only second stages
  always_ff @(posedge link_clk_i) begin
    rst1 <= reset_i;
    rst_l <= rst1;
    din1 <= data_i;
    din_s <= din1;
  end

  // Link side engine: one machine cycle is four link clock phases
  always_comb begin
    shift_ev = phase == `USS_PH_LAST;
    tx_last = tx_sh[`USS_DW:1] == `USS_TX_LAST;
    rx_last = !rx_sh[`USS_DW-1];
    next_phase = phase + 1'b1;
    next_state = state;
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    next_rx_byte = rx_byte;
    next_tx_pend = tx_pend;
    next_rx_hold = rx_hold && go_s;
    next_done_tgl = done_tgl;
    next_rx_tgl = rx_tgl;
    // A request landing mid-reception is kept pending, never dropped
    if (req2 != req3) begin
      next_tx_sh = {`USS_TX_MARK, tx_word};
      next_tx_pend = 1'b1;
    end
    case (state)
      USS_IDLE: begin
        if (tx_pend && shift_ev) begin
          next_state = USS_TX;
        end else if (go_s && !rx_hold && shift_ev) begin
          next_rx_sh = `USS_RX_PRELOAD;
          next_state = USS_RX;
        end
      end
      USS_TX: begin
        if (shift_ev) begin
          next_tx_sh = {1'b0, tx_sh[`USS_DW:1]};
          if (tx_last) begin
            next_state = USS_IDLE;
            next_tx_pend = 1'b0;
            next_done_tgl = !done_tgl;
          end
        end
      end
      USS_RX: begin
        if (shift_ev) begin
          next_rx_sh = {rx_sh[`USS_DW-2:0], din_s};
          if (rx_last) begin
            next_rx_byte = {rx_sh[`USS_DW-2:0], din_s};
            next_state = USS_IDLE;
            next_rx_tgl = !rx_tgl;
            next_rx_hold = 1'b1;
          end
        end
      end
      default: begin
        next_state = USS_IDLE;
      end
    endcase
    // Clock low in the first half of each active cycle
    next_pins.sck = (state == USS_IDLE) || (phase >= `USS_PH_RISE);
    next_pins.dout = tx_sh[0];
    next_pins.doe = state == USS_TX;
  end

  always_ff @(posedge link_clk_i) begin
    if (rst_l) begin
      state <= USS_IDLE;
      phase <= `USS_PH_FIRST;
      tx_sh <= '0;
      rx_sh <= '0;
      rx_byte <= '0;
      tx_pend <= 1'b0;
      rx_hold <= 1'b0;
      done_tgl <= 1'b0;
      rx_tgl <= 1'b0;
      pins <= `USS_PINS_IDLE;
      {req1, req2, req3, go1, go_s} <= '0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      rx_byte <= next_rx_byte;
      tx_pend <= next_tx_pend;
      rx_hold <= next_rx_hold;
      done_tgl <= next_done_tgl;
      rx_tgl <= next_rx_tgl;
      pins <= next_pins;
      {req1, req2, req3} <= {req_tgl, req1, req2};
      {go1, go_s} <= {rx_go, go1};
    end
  end

  assign shift_clk_o = pins.sck;
  assign data_o = pins.dout;
  assign data_oe_o = pins.doe;

  // Checks on the link engine and the core receive done flag
  sequence clk_low_high;
    !shift_clk_o ##1 !shift_clk_o ##1 shift_clk_o ##1 shift_clk_o;
  endsequence
  sequence tx_end;
    state == USS_TX && shift_ev && tx_last;
  endsequence

  load_marker_a: assert property (@(posedge link_clk_i) disable iff (rst_l)
    (state != USS_TX && req2 != req3) |=> tx_sh == {`USS_TX_MARK, $past(tx_word)})
    else $error("marker byte not loaded");
  tx_start_a: assert property (@(posedge link_clk_i) disable iff (rst_l)
    (state == USS_IDLE && tx_pend && shift_ev) |=> state == USS_TX && phase == `USS_PH_FIRST)
    else $error("send did not start on cycle boundary");
  send_drive_a: assert property (@(posedge link_clk_i) disable iff (rst_l)
    (state == USS_TX) |=> data_oe_o && data_o == $past(tx_sh[0]))
    else $error("data pin not driven while sending");
  clk_pulse_a: assert property (@(posedge link_clk_i) disable iff (rst_l)
    (state != USS_IDLE && phase == `USS_PH_FIRST && $past(state) == state)
      |=> clk_low_high)
    else $error("shift clock pulse malformed");
  tx_shift_a: assert property (@(posedge link_clk_i) disable iff (rst_l)
    (state == USS_TX && shift_ev) |=> tx_sh == {1'b0, $past(tx_sh[`USS_DW:1])})
    else $error("transmit shift wrong");
  tx_done_a: assert property (@(posedge link_clk_i) disable iff (rst_l)
    tx_end |=> state == USS_IDLE && done_tgl != $past(done_tgl) ##1 !data_oe_o)
    else $error("send did not end cleanly");
  rx_preload_a: assert property (@(posedge link_clk_i) disable iff (rst_l)
    (state == USS_IDLE && $past(state) == USS_IDLE && next_state == USS_RX)
      |-> go_s ##1 rx_sh == `USS_RX_PRELOAD)
    else $error("receive preload wrong");
  rx_shift_a: assert property (@(posedge link_clk_i) disable iff (rst_l)
    (state == USS_RX && shift_ev) |=> rx_sh == {$past(rx_sh[`USS_DW-2:0]), $past(din_s)})
    else $error("receive shift wrong");
  rx_done_a: assert property (@(posedge link_clk_i) disable iff (rst_l)
    (state == USS_RX && shift_ev && rx_last) |=> rx_byte == rx_sh && state == USS_IDLE)
    else $error("received byte not captured");
  clk_idle_a: assert property (@(posedge link_clk_i) disable iff (rst_l)
    ($past(state) == USS_IDLE && state == USS_IDLE) |=> shift_clk_o)
    else $error("shift clock not idle high");
  rx_flag_a: assert property (@(posedge clk_i) disable iff (reset_i)
    rx_ev |=> receive_done_flag_o && serial_buffer_o == $past(rx_byte) && !rx_go)
    else $error("receive done not raised");
endmodule

// ### hdl/uss_unused_placeholder_none.sv
`timescale 1ns/1ns

// ### tb/uss_peer.sv
/*
 Peer shift register at the link: captures sent bytes on the rising
 shift clock and presents bytes to receive, changing on the falling edge.
 Assumes the device drives the wire only while data_oe_i is high.
*/
`timescale 1ns/1ns
module uss_peer (
  // Link side
  input wire logic shift_clk_i,
  input wire logic data_i,
  input wire logic data_oe_i,
  output logic line_o,
  // Bench side
  input wire logic arm_i,
  input wire logic [7:0] send_i,
  output logic [7:0] got_o
);
  logic [7:0] out_sr = 8'h00;
  logic fresh = 1'b0;
  initial got_o = 8'h00;
  // Undriven wire rises to its weak pull-up level
  assign line_o = data_oe_i ? data_i : (arm_i ? out_sr[0] : 1'b1);
  // Load a byte; its first bit is on the wire before the first pulse
  always @(posedge arm_i) begin
    out_sr = send_i;
    fresh = 1'b1;
  end
  // First falling edge precedes the first sample, so it is skipped
  always @(negedge shift_clk_i) begin
    if (!data_oe_i && arm_i) begin
      if (fresh) fresh <= 1'b0;
      else out_sr <= {~out_sr[0], out_sr[7:1]};
    end
  end
  // Capture sent data LSB first
  always @(posedge shift_clk_i) begin
    if (data_oe_i) got_o <= {line_o, got_o[7:1]};
  end
endmodule

// ### tb/tb_uss_shift_top.sv
/*
 Self-checking bench of the synchronous shift serial port.
 Assumes uss_peer as the far side and the notes' write and flag handshakes.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_uss_shift_top;
  import uss_pkg::*;
  logic clk_i = 1'b0, link_clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0;
  logic [7:0] wr_data_i = 8'h00, send = 8'h00, got, serial_buffer_o;
  logic receive_enable_i = 1'b0, tx_clear_i = 1'b0, rx_clear_i = 1'b0, arm = 1'b0;
  logic wr_ready_o, transmit_done_flag_o, receive_done_flag_o;
  logic shift_clk_o, line, data_o, data_oe_o;
  int fails = 0, compares = 0, pulses = 0, mark = 0;
  logic [7:0] sent_q[$], got_q[$];
  int len_q[$];
  logic [7:0] pat [8] = '{8'h01, 8'h80, 8'ha5, 8'hff, 8'h00, 8'h3c, 8'hc3, 8'h7e};
  uss_shift_top uss_shift_top_inst (.clk_i(clk_i), .reset_i(reset_i),
    .link_clk_i(link_clk_i), .wr_i(wr_i), .wr_data_i(wr_data_i),
    .wr_ready_o(wr_ready_o), .receive_enable_i(receive_enable_i),
    .tx_clear_i(tx_clear_i), .rx_clear_i(rx_clear_i),
    .serial_buffer_o(serial_buffer_o), .transmit_done_flag_o(transmit_done_flag_o),
    .receive_done_flag_o(receive_done_flag_o), .shift_clk_o(shift_clk_o),
    .data_i(line), .data_o(data_o), .data_oe_o(data_oe_o));
  uss_peer uss_peer_inst (.shift_clk_i(shift_clk_o), .data_i(data_o),
    .data_oe_i(data_oe_o), .line_o(line), .arm_i(arm), .send_i(send), .got_o(got));
  // Clocks, link offset in phase
  initial forever #20 clk_i = ~clk_i;
  initial begin
    #7;
    forever #15 link_clk_i = ~link_clk_i;
  end
  // Frame log: pulses and captured byte per sent frame
  always @(posedge shift_clk_o) pulses++;
  always @(negedge data_oe_o) begin
    if (!reset_i) begin
      got_q.push_back(got);
      len_q.push_back(pulses - mark);
      mark = pulses;
    end
  end
  task end_sim;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function bit done(input int w);
    case (w)
      0: return got_q.size() == sent_q.size();
      1: return transmit_done_flag_o === 1'b1;
      default: return receive_done_flag_o === 1'b1;
    endcase
  endfunction
  // Bounded wait for a condition
  task await(input int w);
    for (int i = 0; i < 4000; i++) begin
      if (done(w)) return;
      @(posedge clk_i);
      #2;
    end
    fails++;
    end_sim;
  endtask
  // One write; caller lowers wr_i, so back-to-back writes hold it high
  task wr_byte(input logic [7:0] b, output logic acc);
    wr_i = 1'b1;
    wr_data_i = b;
    acc = wr_ready_o;
    @(posedge clk_i);
    #2;
  endtask
  task pulse_clear(input bit rx);
    if (rx) rx_clear_i = 1'b1;
    else tx_clear_i = 1'b1;
    @(posedge clk_i);
    #2 {rx_clear_i, tx_clear_i} = 2'b00;
  endtask
  initial begin
    logic acc;
    int refused, p0;
    repeat (20) @(posedge clk_i);
    #2 reset_i = 1'b0;
    mark = pulses; // the clock leaving unknown at startup is no frame pulse
    `CHK(shift_clk_o, 1'b1)
    `CHK({data_oe_o, transmit_done_flag_o, receive_done_flag_o}, 3'h0)
    `CHK({wr_ready_o, serial_buffer_o}, 9'h100)
    // Back-to-back writes of all eight patterns, counting FIFO refusals
    refused = 0;
    foreach (pat[i]) begin
      wr_byte(pat[i], acc);
      if (acc) sent_q.push_back(pat[i]);
      else refused++;
    end
    wr_i = 1'b0;
    `CHK(refused > 0, 1'b1)
    await(0);
    repeat (400) @(posedge clk_i);
    `CHK(got_q.size(), sent_q.size())
    foreach (sent_q[i]) begin
      `CHK(got_q[i], sent_q[i])
      `CHK(len_q[i], 8)
    end
    `CHK(transmit_done_flag_o, 1'b1)
    pulse_clear(1'b0);
    `CHK(transmit_done_flag_o, 1'b0)
    // Two receptions; a set done flag holds the next one off
    send = 8'h1e;
    arm = 1'b1;
    p0 = pulses;
    receive_enable_i = 1'b1;
    await(2);
    `CHK(serial_buffer_o, 8'h78)
    `CHK(pulses - p0, 8)
    arm = 1'b0;
    p0 = pulses;
    repeat (200) @(posedge clk_i);
    `CHK(pulses - p0, 0)
    send = 8'hb1;
    arm = 1'b1;
    pulse_clear(1'b1);
    await(2);
    `CHK(serial_buffer_o, 8'h8d)
    `CHK(got_q.size(), sent_q.size())
    arm = 1'b0;
    receive_enable_i = 1'b0;
    pulse_clear(1'b1);
    p0 = pulses;
    repeat (200) @(posedge clk_i);
    `CHK({pulses - p0, receive_done_flag_o}, 33'h0)
    end_sim;
  end
endmodule
